// *** verilog/ddu_pkg.sv ***
/*
  constants and types shared by the two-channel converter update and format logic.
  assumes a processor-side register bus with a page select and one-cycle strobes.
*/
// Function
// [R1] enable bit low: output pin off, channel in low-power shutdown; high: active.
// [R2] control bits 6 and 5 read zero and ignore writes.
// [R3] source 00: output updates on a write to the high data byte.
// [R4] source 01: output updates on timer 3 overflow.
// [R5] source 10: output updates on timer 4 overflow.
// [R6] source 11: output updates on timer 2 overflow.
// [R7] format 000: code 11:8 from high 3:0, code 7:0 from low byte.
// [R8] format 001: upper five bits from high 4:0, lower seven from low 7:1.
// [R9] format 010: upper six bits from high 5:0, lower six from low 7:2.
// [R10] format 011: upper seven bits from high 6:0, lower five from low 7:3.
// [R11] format 1xx: upper eight bits from high byte, lower four from low 7:4.
// [R12] each low data byte is an 8-bit read/write register.
// [R13] each high data byte is an 8-bit register holding the upper byte.
// [R14] second channel has its own identical, independent registers.
// [R15] on-demand mode holds low byte writes until the high byte is written.
// [R16] timer modes hold both bytes; selected overflow copies them to the latch.
// [R17] converter code comes only from a latch loaded on update events.
package ddu_pkg;

    // register addresses within a page
    localparam logic [7:0] ADDR_DATA_LOW = 8'hd2;
    localparam logic [7:0] ADDR_DATA_HIGH = 8'hd3;
    localparam logic [7:0] ADDR_CONTROL = 8'hd4;

    // page that selects each channel
    localparam logic [7:0] PAGE_CH0 = 8'h00;
    localparam logic [7:0] PAGE_CH1 = 8'h01;

    // reset values
    localparam logic [7:0] RESET_DATA_LOW = 8'h00;
    localparam logic [7:0] RESET_DATA_HIGH = 8'h00;
    localparam logic [7:0] RESET_CONTROL = 8'h00;
    localparam logic [11:0] RESET_CODE = 12'h000;
    localparam logic [7:0] RESET_RDATA = 8'h00;

    // control field positions
    localparam int CTRL_ENABLE_BIT = 7;
    localparam int CTRL_SOURCE_LSB = 3;
    localparam int CTRL_JUST_LSB = 0;
    localparam logic [7:0] CTRL_WRITE_MASK = 8'h9f;

    // update source codes
    localparam logic [1:0] SRC_ON_DEMAND = 2'h0;
    localparam logic [1:0] SRC_TIMER3 = 2'h1;
    localparam logic [1:0] SRC_TIMER4 = 2'h2;
    localparam logic [1:0] SRC_TIMER2 = 2'h3;

    // justification codes; any code with bit 2 set is the 8/4 split
    localparam logic [2:0] JUST_4_8 = 3'h0;
    localparam logic [2:0] JUST_5_7 = 3'h1;
    localparam logic [2:0] JUST_6_6 = 3'h2;
    localparam logic [2:0] JUST_7_5 = 3'h3;

    typedef struct packed {
        logic [7:0] data_low;
        logic [7:0] data_high;
        logic [7:0] control;
    } ddu_chan_state_t;

    typedef struct packed {
        logic [7:0] rdata;
        logic [11:0] code0;
        logic [11:0] code1;
        logic enable0;
        logic enable1;
        logic shutdown0;
        logic shutdown1;
    } ddu_top_state_t;

endpackage

// *** verilog/ddu_chan_if.sv ***
/*
  carrier between the bus decode and one converter channel.
  assumes the top drives the strobes and the timer pulses for one cycle each.
*/
`timescale 1ns/100ps
interface ddu_chan_if;
    logic wr_low;
    logic wr_high;
    logic wr_ctrl;
    logic [7:0] wdata;
    logic tmr2_ovf;
    logic tmr3_ovf;
    logic tmr4_ovf;
    logic [7:0] data_low;
    logic [7:0] data_high;
    logic [7:0] control;
    logic update;
    logic [11:0] code;

    modport bus (
        output wr_low, wr_high, wr_ctrl, wdata, tmr2_ovf, tmr3_ovf, tmr4_ovf,
        input data_low, data_high, control, update, code
    );
    modport chan (
        input wr_low, wr_high, wr_ctrl, wdata, tmr2_ovf, tmr3_ovf, tmr4_ovf,
        output data_low, data_high, control, update, code
    );
endinterface // ddu_chan_if

// *** verilog/ddu_fmt.sv ***
/*
  justification of the two data bytes into a 12-bit converter code.
  assumes purely combinational use; no state.
*/
`timescale 1ns/100ps
module ddu_fmt (
    // format select
    input wire logic [2:0] just,
    // data bytes
    input wire logic [7:0] data_high,
    input wire logic [7:0] data_low,
    // assembled code
    output logic [11:0] code
);

    // bits outside the selected window are dropped, not shifted in
    always_comb
    begin
        if (just[2])
        begin
            code = {data_high, data_low[7:4]}; // [R11]
        end
        else
        begin
            case (just)
                ddu_pkg::JUST_4_8: code = {data_high[3:0], data_low}; // [R7]
                ddu_pkg::JUST_5_7: code = {data_high[4:0], data_low[7:1]}; // [R8]
                ddu_pkg::JUST_6_6: code = {data_high[5:0], data_low[7:2]}; // [R9]
                ddu_pkg::JUST_7_5: code = {data_high[6:0], data_low[7:3]}; // [R10]
                default: code = {data_high, data_low[7:4]};
            endcase
        end
    end

endmodule // ddu_fmt

// *** verilog/ddu_chan.sv ***
/*
  one converter channel: data and control registers, update selection, formatting.
  assumes clk and rst synchronous, active-high reset; strobes last one cycle.
*/
`timescale 1ns/100ps
module ddu_chan (
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // link to the bus decode
    ddu_chan_if.chan cif
);

    ddu_pkg::ddu_chan_state_t cur_reg;
    ddu_pkg::ddu_chan_state_t cur_next;
    logic [1:0] source;

    // register writes; the bytes simply hold until the update event copies them
    always_comb
    begin
        cur_next = cur_reg;
        if (cif.wr_low)
        begin
            cur_next.data_low = cif.wdata; // [R12] [R15] [R16]
        end
        if (cif.wr_high)
        begin
            cur_next.data_high = cif.wdata; // [R13] [R16]
        end
        if (cif.wr_ctrl)
        begin
            cur_next.control = cif.wdata & ddu_pkg::CTRL_WRITE_MASK; // [R2]
        end
    end

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            cur_reg.data_low <= ddu_pkg::RESET_DATA_LOW;
            cur_reg.data_high <= ddu_pkg::RESET_DATA_HIGH;
            cur_reg.control <= ddu_pkg::RESET_CONTROL;
        end
        else
        begin
            cur_reg <= cur_next;
        end
    end

    assign source = cur_reg.control[ddu_pkg::CTRL_SOURCE_LSB +: 2];

    // update event from the source chosen by the current control value
    always_comb
    begin
        case (source)
            ddu_pkg::SRC_ON_DEMAND: cif.update = cif.wr_high; // [R3] [R15]
            ddu_pkg::SRC_TIMER3: cif.update = cif.tmr3_ovf; // [R4]
            ddu_pkg::SRC_TIMER4: cif.update = cif.tmr4_ovf; // [R5]
            ddu_pkg::SRC_TIMER2: cif.update = cif.tmr2_ovf; // [R6]
            default: cif.update = 1'b0;
        endcase
    end

    // format from the post-write bytes so a same-cycle write is not missed
    ddu_fmt u_fmt (
        .just(cur_reg.control[ddu_pkg::CTRL_JUST_LSB +: 3]),
        .data_high(cur_next.data_high),
        .data_low(cur_next.data_low),
        .code(cif.code)
    );

    assign cif.data_low = cur_reg.data_low;
    assign cif.data_high = cur_reg.data_high;
    assign cif.control = cur_reg.control;

endmodule // ddu_chan

// *** verilog/ddu_top.sv ***
/*
  two-channel converter register block: page/address decode, read-back,
  per-channel registers and the converter input latches.
  assumes a register bus synchronous to clk with one-cycle read and write strobes,
  a page value held by the core, and one-cycle timer overflow pulses.
*/
`timescale 1ns/100ps
module ddu_top (
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // register bus
    input wire logic [7:0] sfr_page,
    input wire logic [7:0] sfr_addr,
    input wire logic sfr_wr,
    input wire logic sfr_rd,
    input wire logic [7:0] sfr_wdata,
    output logic [7:0] sfr_rdata,
    // timer overflow pulses
    input wire logic timer2_overflow,
    input wire logic timer3_overflow,
    input wire logic timer4_overflow,
    // channel 0 analog side
    output logic [11:0] channel0_code,
    output logic channel0_output_enable,
    output logic channel0_shutdown,
    // channel 1 analog side
    output logic [11:0] channel1_code,
    output logic channel1_output_enable,
    output logic channel1_shutdown
);

    ddu_pkg::ddu_top_state_t st_reg;
    ddu_pkg::ddu_top_state_t st_next;

    logic page_ch0;
    logic page_ch1;
    logic hit_low;
    logic hit_high;
    logic hit_ctrl;

    ddu_chan_if ch0 ();
    ddu_chan_if ch1 ();

    // page selects the channel, address selects the register
    assign page_ch0 = (sfr_page == ddu_pkg::PAGE_CH0);
    assign page_ch1 = (sfr_page == ddu_pkg::PAGE_CH1);
    assign hit_low = (sfr_addr == ddu_pkg::ADDR_DATA_LOW);
    assign hit_high = (sfr_addr == ddu_pkg::ADDR_DATA_HIGH);
    assign hit_ctrl = (sfr_addr == ddu_pkg::ADDR_CONTROL);

    // channel 0 write strobes
    assign ch0.wr_low = sfr_wr & page_ch0 & hit_low;
    assign ch0.wr_high = sfr_wr & page_ch0 & hit_high;
    assign ch0.wr_ctrl = sfr_wr & page_ch0 & hit_ctrl;
    assign ch0.wdata = sfr_wdata;

    // channel 1 write strobes, decoded on its own page
    assign ch1.wr_low = sfr_wr & page_ch1 & hit_low; // [R14]
    assign ch1.wr_high = sfr_wr & page_ch1 & hit_high; // [R14]
    assign ch1.wr_ctrl = sfr_wr & page_ch1 & hit_ctrl; // [R14]
    assign ch1.wdata = sfr_wdata;

    // both channels see all three timers; each picks its own
    assign ch0.tmr2_ovf = timer2_overflow;
    assign ch0.tmr3_ovf = timer3_overflow;
    assign ch0.tmr4_ovf = timer4_overflow;
    assign ch1.tmr2_ovf = timer2_overflow;
    assign ch1.tmr3_ovf = timer3_overflow;
    assign ch1.tmr4_ovf = timer4_overflow;

    // the two channels are the same module, kept fully apart
    ddu_chan u_ch0 (
        .clk(clk),
        .rst(rst),
        .cif(ch0)
    );

    ddu_chan u_ch1 (
        .clk(clk),
        .rst(rst),
        .cif(ch1)
    );

    // read-back, latches and enables
    always_comb
    begin
        st_next = st_reg;

        // read data is registered and holds until the next read
        if (sfr_rd)
        begin
            st_next.rdata = ddu_pkg::RESET_RDATA; // unmapped reads return zero
            if (page_ch0 && hit_low)
            begin
                st_next.rdata = ch0.data_low; // [R12]
            end
            else if (page_ch0 && hit_high)
            begin
                st_next.rdata = ch0.data_high; // [R13]
            end
            else if (page_ch0 && hit_ctrl)
            begin
                st_next.rdata = ch0.control; // [R2]
            end
            else if (page_ch1 && hit_low)
            begin
                st_next.rdata = ch1.data_low; // [R14]
            end
            else if (page_ch1 && hit_high)
            begin
                st_next.rdata = ch1.data_high; // [R14]
            end
            else if (page_ch1 && hit_ctrl)
            begin
                st_next.rdata = ch1.control; // [R14]
            end
        end

        // converter latches move only on an update event, never on partial writes
        if (ch0.update)
        begin
            st_next.code0 = ch0.code; // [R17] [R16]
        end
        if (ch1.update)
        begin
            st_next.code1 = ch1.code; // [R17] [R14]
        end

        // enable bit drives the pin enable; shutdown is its complement
        st_next.enable0 = ch0.control[ddu_pkg::CTRL_ENABLE_BIT]; // [R1]
        st_next.shutdown0 = ~ch0.control[ddu_pkg::CTRL_ENABLE_BIT]; // [R1]
        st_next.enable1 = ch1.control[ddu_pkg::CTRL_ENABLE_BIT]; // [R1]
        st_next.shutdown1 = ~ch1.control[ddu_pkg::CTRL_ENABLE_BIT]; // [R1]
    end

    // single state register; shutdown asserted during and right after reset
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            st_reg.rdata <= ddu_pkg::RESET_RDATA;
            st_reg.code0 <= ddu_pkg::RESET_CODE;
            st_reg.code1 <= ddu_pkg::RESET_CODE;
            st_reg.enable0 <= 1'b0;
            st_reg.enable1 <= 1'b0;
            st_reg.shutdown0 <= 1'b1;
            st_reg.shutdown1 <= 1'b1;
        end
        else
        begin
            st_reg <= st_next;
        end
    end

    // outputs straight from the state register
    assign sfr_rdata = st_reg.rdata;
    assign channel0_code = st_reg.code0;
    assign channel0_output_enable = st_reg.enable0;
    assign channel0_shutdown = st_reg.shutdown0;
    assign channel1_code = st_reg.code1;
    assign channel1_output_enable = st_reg.enable1;
    assign channel1_shutdown = st_reg.shutdown1;

endmodule // ddu_top

// *** bench/ddu_timer_model.sv ***
/*
  stand-in for the three reload timers that feed the converter block.
  assumes the bench requests an overflow by raising one fire bit for one cycle.
*/
`timescale 1ns/100ps
module ddu_timer_model (
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // request bits: 0 timer 2, 1 timer 3, 2 timer 4
    input wire logic [2:0] fire,
    // overflow pulses
    output logic timer2_overflow,
    output logic timer3_overflow,
    output logic timer4_overflow
);
    // one registered pulse per request cycle, so the pulse never overlaps a bench edge
    always_ff @(posedge clk)
    begin
        timer2_overflow <= !rst && fire[0];
        timer3_overflow <= !rst && fire[1];
        timer4_overflow <= !rst && fire[2];
    end
endmodule // ddu_timer_model

// *** bench/ddu_assertions.sv ***
/*
  port checker for the two-channel converter register block.
  assumes it is bound to ddu_top and sees only its ports.
*/
`timescale 1ns/100ps
module ddu_assertions (
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // register bus
    input wire logic [7:0] sfr_page,
    input wire logic [7:0] sfr_addr,
    input wire logic sfr_wr,
    input wire logic sfr_rd,
    input wire logic [7:0] sfr_wdata,
    input wire logic [7:0] sfr_rdata,
    // timers and analog side
    input wire logic timer2_overflow,
    input wire logic timer3_overflow,
    input wire logic timer4_overflow,
    input wire logic [11:0] channel0_code,
    input wire logic channel0_output_enable,
    input wire logic channel0_shutdown,
    input wire logic [11:0] channel1_code,
    input wire logic channel1_output_enable,
    input wire logic channel1_shutdown
);
    logic tmr;
    logic ev0;
    logic ev1;
    // possible update causes; any timer counts since the source field is not visible here
    assign tmr = timer2_overflow || timer3_overflow || timer4_overflow;
    assign ev0 = tmr || (sfr_wr && sfr_page == ddu_pkg::PAGE_CH0 && sfr_addr == ddu_pkg::ADDR_DATA_HIGH);
    assign ev1 = tmr || (sfr_wr && sfr_page == ddu_pkg::PAGE_CH1 && sfr_addr == ddu_pkg::ADDR_DATA_HIGH);

    default clocking @(posedge clk); endclocking
    default disable iff (rst);

    // low byte write, then a read of the same place with nothing in between
    sequence s_wr_low;
        sfr_wr && sfr_addr == ddu_pkg::ADDR_DATA_LOW && sfr_page <= ddu_pkg::PAGE_CH1;
    endsequence
    sequence s_rd_low;
        sfr_rd && !sfr_wr && sfr_addr == ddu_pkg::ADDR_DATA_LOW && sfr_page == $past(sfr_page, 2);
    endsequence

    property p_shutdown_inv;
        channel0_shutdown == !channel0_output_enable && channel1_shutdown == !channel1_output_enable;
    endproperty
    property p_enable0;
        sfr_wr && sfr_page == ddu_pkg::PAGE_CH0 && sfr_addr == ddu_pkg::ADDR_CONTROL
            |-> ##2 channel0_output_enable == ($past(sfr_wdata, 2) >= 8'h80);
    endproperty
    property p_ctrl_unused;
        sfr_rd && sfr_addr == ddu_pkg::ADDR_CONTROL ##1 !sfr_rd |=> sfr_rdata[6:5] == 2'h0;
    endproperty
    property p_unmapped;
        sfr_rd && sfr_page > ddu_pkg::PAGE_CH1 ##1 !sfr_rd |=> sfr_rdata == 8'h00;
    endproperty
    property p_rdata_hold;
        !sfr_rd ##1 !sfr_rd |=> $stable(sfr_rdata);
    endproperty
    property p_code0_hold;
        !ev0 ##1 !ev0 |=> $stable(channel0_code);
    endproperty
    property p_code1_hold;
        !ev1 ##1 !ev1 |=> $stable(channel1_code);
    endproperty
    property p_low_readback;
        s_wr_low ##1 !sfr_wr ##1 s_rd_low ##1 !sfr_rd |=> sfr_rdata == $past(sfr_wdata, 4);
    endproperty

    a_shutdown_inv: assert property (p_shutdown_inv) else $error("shutdown not inverse of enable");
    a_enable0: assert property (p_enable0) else $error("enable did not follow control bit");
    a_ctrl_unused: assert property (p_ctrl_unused) else $error("unused control bits read nonzero");
    a_unmapped: assert property (p_unmapped) else $error("unmapped page read nonzero");
    a_rdata_hold: assert property (p_rdata_hold) else $error("read data moved without read");
    a_code0_hold: assert property (p_code0_hold) else $error("code 0 moved without update");
    a_code1_hold: assert property (p_code1_hold) else $error("code 1 moved without update");
    a_low_readback: assert property (p_low_readback) else $error("low byte readback wrong");
endmodule // ddu_assertions

bind ddu_top ddu_assertions u_chk (.clk, .rst, .sfr_page, .sfr_addr, .sfr_wr, .sfr_rd, .sfr_wdata,
    .sfr_rdata, .timer2_overflow, .timer3_overflow, .timer4_overflow, .channel0_code,
    .channel0_output_enable, .channel0_shutdown, .channel1_code, .channel1_output_enable, .channel1_shutdown);

// *** bench/ddu_top_test.sv ***
/*
  self-checking bench for the converter register block.
  assumes the timer model and the bound checker are compiled alongside.
*/
`timescale 1ns/100ps
module ddu_top_test;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic [7:0] sfr_page = 8'h00, sfr_addr = 8'h00, sfr_wdata = 8'h00, sfr_rdata, lo, hi;
    logic sfr_wr = 1'b0, sfr_rd = 1'b0;
    logic [2:0] fire = 3'h0, sel;
    logic timer2_overflow, timer3_overflow, timer4_overflow;
    logic channel0_output_enable, channel0_shutdown, channel1_output_enable, channel1_shutdown;
    logic [11:0] channel0_code, channel1_code, prev0, prev1;
    int error_cnt = 0;
    int compares = 0;

    always #4 clk = ~clk;

    ddu_top u_dut (.clk, .rst, .sfr_page, .sfr_addr, .sfr_wr, .sfr_rd, .sfr_wdata, .sfr_rdata,
        .timer2_overflow, .timer3_overflow, .timer4_overflow, .channel0_code, .channel0_output_enable,
        .channel0_shutdown, .channel1_code, .channel1_output_enable, .channel1_shutdown);
    ddu_timer_model u_tmr (.clk, .rst, .fire, .timer2_overflow, .timer3_overflow, .timer4_overflow);

    task automatic check(input logic [11:0] seen, input logic [11:0] exp);
        compares++;
        if (seen !== exp)
        begin
            error_cnt++;
            $display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic end_of_test;
        $display("comparisons %0d, mismatches %0d", compares, error_cnt);
        if (error_cnt == 0 && compares > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask

    // one-cycle write strobe; returns at the edge that takes it
    task automatic wr(input logic [7:0] pg, input logic [7:0] ad, input logic [7:0] d);
        @(posedge clk);
        sfr_page <= pg;
        sfr_addr <= ad;
        sfr_wdata <= d;
        sfr_wr <= 1'b1;
        @(posedge clk);
        sfr_wr <= 1'b0;
    endtask

    // read data is compared an edge late so either load edge is covered
    task automatic rd(input logic [7:0] pg, input logic [7:0] ad, input logic [7:0] exp);
        @(posedge clk);
        sfr_page <= pg;
        sfr_addr <= ad;
        sfr_rd <= 1'b1;
        @(posedge clk);
        sfr_rd <= 1'b0;
        @(posedge clk);
        #1;
        check({4'h0, sfr_rdata}, {4'h0, exp});
    endtask

    task automatic settle;
        @(posedge clk);
        #1;
    endtask

    // overflow request, then wait until the latch has settled
    task automatic pulse(input logic [2:0] m);
        @(posedge clk);
        fire <= m;
        @(posedge clk);
        fire <= 3'h0;
        repeat (3) @(posedge clk);
        #1;
    endtask

    function automatic logic [11:0] fmt(input logic [2:0] j, input logic [7:0] h, input logic [7:0] l);
        case (j)
            3'h0: return {h[3:0], l};
            3'h1: return {h[4:0], l[7:1]};
            3'h2: return {h[5:0], l[7:2]};
            3'h3: return {h[6:0], l[7:3]};
            default: return {h, l[7:4]};
        endcase
    endfunction

    // hang guard
    initial
    begin
        repeat (20000) @(posedge clk);
        error_cnt++;
        end_of_test();
    end

    initial
    begin
        repeat (10) @(posedge clk);
        rst <= 1'b0;
        for (int a = 0; a < 6; a++)
            rd(a[8:1], ddu_pkg::ADDR_DATA_LOW + {6'h0, a[0], 1'b0} + (a[1:0] == 2'h1 ? 8'h1 : 8'h0), 8'h00);
        rd(ddu_pkg::PAGE_CH0, ddu_pkg::ADDR_DATA_HIGH, 8'h00);
        rd(ddu_pkg::PAGE_CH1, ddu_pkg::ADDR_CONTROL, 8'h00);
        check(channel0_code, ddu_pkg::RESET_CODE);
        check(channel1_code, ddu_pkg::RESET_CODE);
        check({10'h0, channel0_shutdown, channel1_shutdown}, 12'h003);
        check({10'h0, channel0_output_enable, channel1_output_enable}, 12'h000);
        $display("test reset done");
        wr(ddu_pkg::PAGE_CH0, ddu_pkg::ADDR_CONTROL, 8'hff);
        rd(ddu_pkg::PAGE_CH0, ddu_pkg::ADDR_CONTROL, 8'h9f);
        check({9'h0, channel0_output_enable, channel0_shutdown, channel1_output_enable}, 12'h004);
        wr(ddu_pkg::PAGE_CH0, ddu_pkg::ADDR_CONTROL, 8'h00);
        wr(8'h02, ddu_pkg::ADDR_CONTROL, 8'h80);
        rd(8'h02, ddu_pkg::ADDR_CONTROL, 8'h00);
        check({10'h0, channel0_output_enable, channel0_shutdown}, 12'h001);
        $display("test control done");
        prev0 = 12'h000;
        for (int j = 0; j < 8; j++)
        begin
            lo = 8'h96 + j[7:0];
            hi = 8'hc3 - j[7:0];
            wr(ddu_pkg::PAGE_CH0, ddu_pkg::ADDR_CONTROL, {5'h0, j[2:0]});
            wr(ddu_pkg::PAGE_CH0, ddu_pkg::ADDR_DATA_LOW, lo);
            rd(ddu_pkg::PAGE_CH0, ddu_pkg::ADDR_DATA_LOW, lo);
            check(channel0_code, prev0);
            wr(ddu_pkg::PAGE_CH0, ddu_pkg::ADDR_DATA_HIGH, hi);
            settle();
            prev0 = fmt(j[2:0], hi, lo);
            check(channel0_code, prev0);
        end
        $display("test formats done");
        prev1 = 12'h000;
        for (int s = 1; s < 4; s++)
        begin
            sel = (s == 1) ? 3'h2 : (s == 2) ? 3'h4 : 3'h1;
            lo = 8'h5a + s[7:0];
            hi = 8'ha0 + s[7:0];
            wr(ddu_pkg::PAGE_CH1, ddu_pkg::ADDR_CONTROL, {3'h0, s[1:0], 3'h4});
            wr(ddu_pkg::PAGE_CH1, ddu_pkg::ADDR_DATA_LOW, lo);
            wr(ddu_pkg::PAGE_CH1, ddu_pkg::ADDR_DATA_HIGH, hi);
            rd(ddu_pkg::PAGE_CH1, ddu_pkg::ADDR_DATA_HIGH, hi);
            check(channel1_code, prev1);
            pulse(~sel);
            check(channel1_code, prev1);
            pulse(sel);
            prev1 = fmt(3'h4, hi, lo);
            check(channel1_code, prev1);
            check(channel0_code, prev0);
        end
        wr(ddu_pkg::PAGE_CH1, ddu_pkg::ADDR_CONTROL, 8'h80);
        settle();
        check({9'h0, channel1_output_enable, channel1_shutdown, channel0_output_enable}, 12'h004);
        $display("test timers done");
        // second channel on demand with the nibble/byte split
        lo = 8'h3c;
        hi = 8'h7e;
        wr(ddu_pkg::PAGE_CH1, ddu_pkg::ADDR_DATA_LOW, lo);
        settle();
        check(channel1_code, prev1);
        wr(ddu_pkg::PAGE_CH1, ddu_pkg::ADDR_DATA_HIGH, hi);
        settle();
        prev1 = fmt(3'h0, hi, lo);
        check(channel1_code, prev1);
        check(channel0_code, prev0);
        $display("test second channel on demand done");
        end_of_test();
    end
endmodule // ddu_top_test
